// *** ext_register_bus_ctrl.sv ***
// pin-level control: external register bus, halt, interrupts, reset vector, user pins
`include "ext_bus_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ext_register_bus_ctrl
  import ext_bus_pkg::*;
(
  // clock and resets
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 chip_clear_n,
  // core-side access request
  input  wire logic                 acc_req,
  input  wire logic                 acc_read,
  input  wire logic [`SEL_W-1:0]    acc_sel,
  input  wire logic [`DATA_W-1:0]   acc_wdata,
  output logic                      acc_done,
  output logic      [`DATA_W-1:0]   acc_rdata,
  // external register bus pins
  input  wire logic [`DATA_W-1:0]   ext_data_in,
  output logic      [`DATA_W-1:0]   ext_data_out,
  output logic                      ext_data_oe,
  output logic                      ext_bus_direction,
  output logic      [`SEL_W-1:0]    ext_reg_select,
  output logic                      ext_data_strobe,
  input  wire logic                 ext_ready,
  // program memory vector port
  output logic      [`PC_W-1:0]     vec_addr,
  output logic                      vec_rd,
  input  wire logic [`PC_W-1:0]     vec_data,
  // execution control
  input  wire logic                 halt,
  input  wire logic                 insn_end,
  input  wire logic                 irq_enable,
  input  wire logic [2:0]           interrupt_request_lines,
  output logic                      pc_load,
  output logic      [`PC_W-1:0]     pc_load_value,
  output logic                      exec_nop,
  output logic                      pc_hold,
  output logic                      irq_taken,
  output logic      [1:0]           irq_num,
  // user pins
  input  wire logic [1:0]           branch_test_inputs,
  output logic      [1:0]           branch_test_sync,
  input  wire logic [1:0]           status_user_bits,
  output logic      [1:0]           user_flag_outputs
);

  ////////////////////////////////////////////////////////////////////////////
  core_state_t state_reg;
  logic        clr_meta_reg;
  logic        clr_sync_reg;
  logic        int_rst;
  logic [2:0]  irq_meta_reg;
  logic [2:0]  irq_sync_reg;
  logic [2:0]  irq_prev_reg;
  logic [2:0]  irq_pend_reg;
  logic [2:0]  irq_rise;
  logic [1:0]  irq_sel;
  logic        irq_any;
  logic        rd_cycle_reg;
  logic [1:0]  irq_arm_reg;

  function automatic logic [1:0] irq_pick(input logic [2:0] p);
    if (p[0])
      irq_pick = 2'd0;
    else if (p[1])
      irq_pick = 2'd1;
    else
      irq_pick = 2'd2;
  endfunction

  function automatic logic [`PC_W-1:0] irq_vector(input logic [1:0] n);
    case (n)
      2'd0:    irq_vector = `VEC_INT0;
      2'd1:    irq_vector = `VEC_INT1;
      default: irq_vector = `VEC_INT2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset: asserted at once by the pin, released through two flops
  always_ff @(posedge ref_clk or negedge chip_clear_n) begin
    if (!chip_clear_n) begin
      clr_meta_reg <= 1'b1;
      clr_sync_reg <= 1'b1;
    end else begin
      clr_meta_reg <= 1'b0;
      clr_sync_reg <= clr_meta_reg;
    end
  end

  // the pin presets clr_sync_reg at once, so no clock is needed to assert
  assign int_rst = rst | clr_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // branch test inputs
  sync2 #(.W(2)) u_branch_sync (
    .ref_clk  (ref_clk),
    .rst      (int_rst),
    .async_in (branch_test_inputs),
    .sync_out (branch_test_sync)
  );

  // user outputs are inverted status bits, lower bit to pin zero
  always_ff @(posedge ref_clk) begin
    if (int_rst)
      user_flag_outputs <= 2'b11;
    else begin
      user_flag_outputs[0] <= ~status_user_bits[`USER_BIT_LO];
      user_flag_outputs[1] <= ~status_user_bits[`USER_BIT_HI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt edge detection and pending flags
  // edges are ignored until the synchroniser has refilled after reset,
  // so a line that idles high raises no request
  assign irq_rise = irq_sync_reg & ~irq_prev_reg & {3{irq_arm_reg == 2'h3}};
  assign irq_any  = |irq_pend_reg;
  assign irq_sel  = irq_pick(irq_pend_reg);

  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      irq_meta_reg <= 3'b000;
      irq_sync_reg <= 3'b000;
      irq_prev_reg <= 3'b000;
    end else begin
      irq_meta_reg <= interrupt_request_lines;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (int_rst)
      irq_arm_reg <= 2'h0;
    else if (irq_arm_reg != 2'h3)
      irq_arm_reg <= irq_arm_reg + 2'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (int_rst)
      irq_pend_reg <= 3'b000;
    else begin
      for (int i = 0; i < 3; i++) begin
        if (irq_rise[i])
          irq_pend_reg[i] <= 1'b1; // set wins over clear
        else if (state_reg == st_irq_vec && irq_num == i[1:0])
          irq_pend_reg[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: reset vector, run, external access, halt, interrupt entry
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      state_reg    <= st_reset;
      irq_num      <= 2'd0;
    end else begin
      case (state_reg)
        st_reset:
          state_reg <= st_fetch_vec;
        st_fetch_vec:
          state_reg <= st_run;
        st_run: begin
          if (insn_end && irq_any && irq_enable) begin
            irq_num   <= irq_sel;
            state_reg <= st_irq_vec;
          end else if (halt) begin
            state_reg <= st_halt;
          end else if (acc_req) begin
            state_reg <= st_access;
          end
        end
        st_access:
          if (ext_ready)
            state_reg <= st_run;
        st_halt:
          if (irq_any && irq_enable) begin
            irq_num   <= irq_sel;
            state_reg <= st_irq_vec;
          end
        // the core pushes the pc after the halt, so return resumes past it
        st_irq_vec:
          state_reg <= st_run;
        default:
          state_reg <= st_reset;
      endcase
    end
  end

  // vector fetch address and pc load
  always_comb begin
    vec_rd   = 1'b0;
    vec_addr = `VEC_RESET;
    case (state_reg)
      st_reset: begin
        vec_rd   = 1'b1;
        vec_addr = `VEC_RESET;
      end
      st_irq_vec: begin
        vec_rd   = 1'b1;
        vec_addr = irq_vector(irq_num);
      end
      default: begin
        vec_rd   = 1'b0;
        vec_addr = `VEC_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      pc_load       <= 1'b0;
      pc_load_value <= `VEC_RESET;
      irq_taken     <= 1'b0;
    end else begin
      pc_load       <= (state_reg == st_reset) || (state_reg == st_irq_vec);
      pc_load_value <= vec_data;
      irq_taken     <= (state_reg == st_irq_vec);
    end
  end

  assign exec_nop = (state_reg == st_halt);
  assign pc_hold  = (state_reg == st_halt) || (state_reg == st_access && !ext_ready);

  ////////////////////////////////////////////////////////////////////////////
  // external register bus pins
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      ext_reg_select <= `SEL_RST;
      ext_data_out   <= `DATA_RST;
      rd_cycle_reg   <= 1'b0;
    end else if (state_reg == st_run && acc_req && !halt && !(insn_end && irq_any && irq_enable)) begin
      ext_reg_select <= acc_sel;
      ext_data_out   <= acc_wdata;
      rd_cycle_reg   <= acc_read;
    end else if (state_reg == st_access && ext_ready) begin
      rd_cycle_reg   <= 1'b0;
    end
  end

  // select and data frozen while not ready
  assign ext_bus_direction = rd_cycle_reg;
  assign ext_data_oe       = ~rd_cycle_reg;
  assign ext_data_strobe   = ~(state_reg == st_access);
  assign acc_done          = (state_reg == st_access) && ext_ready;

  always_ff @(posedge ref_clk) begin
    if (int_rst)
      acc_rdata <= `DATA_RST;
    else if (state_reg == st_access && ext_ready && rd_cycle_reg)
      acc_rdata <= ext_data_in;
  end

endmodule
`default_nettype wire

// *** ext_bus_cfg.svh ***
// constants of the external register bus control block
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define DATA_W        16
`define SEL_W         3
`define PC_W          12
`define VEC_INT0      12'hfff
`define VEC_INT1      12'hffe
`define VEC_INT2      12'hffd
`define VEC_RESET     12'hffc
`define DATA_RST      16'h0000
`define SEL_RST       3'h0
`define USER_BIT_LO   0
`define USER_BIT_HI   1
`endif

// *** ext_bus_pkg.sv ***
// types of the external register bus control block
package ext_bus_pkg;
  typedef enum logic [2:0] {
    st_reset,
    st_fetch_vec,
    st_run,
    st_access,
    st_halt,
    st_irq_vec
  } core_state_t;
endpackage

// *** sync2.sv ***
// two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** ext_bus_properties.sv ***
// assertions on the pins of the external register bus control block
`timescale 1ns/10ps
`default_nettype none
module ext_bus_properties (
  // clock and resets
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        chip_clear_n,
  // core side
  input wire logic        acc_read,
  input wire logic [2:0]  acc_sel,
  input wire logic [15:0] acc_wdata,
  input wire logic        acc_done,
  input wire logic [15:0] acc_rdata,
  // bus pins
  input wire logic [15:0] ext_data_in,
  input wire logic [15:0] ext_data_out,
  input wire logic        ext_bus_direction,
  input wire logic [2:0]  ext_reg_select,
  input wire logic        ext_data_strobe,
  input wire logic        ext_ready,
  input wire logic        ext_data_oe,
  // control and user pins
  input wire logic        halt,
  input wire logic        exec_nop,
  input wire logic        pc_hold,
  input wire logic        vec_rd,
  input wire logic        pc_load,
  input wire logic [1:0]  branch_test_inputs,
  input wire logic [1:0]  branch_test_sync,
  input wire logic [1:0]  status_user_bits,
  input wire logic [1:0]  user_flag_outputs
);
  logic [2:0] settle_reg;
  // checks wait until the design's own two-flop reset release has passed
  always_ff @(posedge ref_clk or negedge chip_clear_n) begin
    if (!chip_clear_n)
      settle_reg <= 3'h0;
    else if (rst)
      settle_reg <= 3'h0;
    else if (settle_reg != 3'h4)
      settle_reg <= settle_reg + 3'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !chip_clear_n || settle_reg != 3'h4);
  ////////////////////////////////////////
  a_turn_select:
    assert property ($fell(ext_data_strobe) |->
      ext_bus_direction == $past(acc_read) && ext_reg_select == $past(acc_sel)) else $error("bad turn or select");
  a_write_data:
    assert property ($fell(ext_data_strobe) && !ext_bus_direction |-> ext_data_out == $past(acc_wdata))
      else $error("bad write data");
  a_stretch_hold:
    assert property (!ext_data_strobe && !ext_ready |=> !ext_data_strobe && $stable(ext_bus_direction)
      && $stable(ext_reg_select) && $stable(ext_data_out)) else $error("stretch lost");
  a_ready_done:
    assert property (!ext_data_strobe && ext_ready |-> acc_done ##1 ext_data_strobe) else $error("no finish");
  a_read_capture:
    assert property (acc_done && acc_read |=> acc_rdata == $past(ext_data_in)) else $error("bad read capture");
  a_user_invert:
    assert property (user_flag_outputs == ~$past(status_user_bits)) else $error("bad user flags");
  a_branch_sync:
    assert property (branch_test_sync == $past(branch_test_inputs, 2)) else $error("bad sync");
  a_halt_nop:
    assert property ($rose(halt) |=> pc_hold && exec_nop) else $error("halt not held");
  a_release_read:
    assert property (!ext_data_oe |-> !ext_data_strobe && ext_bus_direction) else $error("bus released outside read");
  a_vec_fetch:
    assert property (pc_load |-> $past(vec_rd)) else $error("pc load without vector fetch");
endmodule
bind ext_register_bus_ctrl ext_bus_properties props (.*);
`default_nettype wire

// *** ext_periph.sv ***
// peripheral register model on the far side of the external bus
`timescale 1ns/10ps
`default_nettype none
module ext_periph (
  // clock and stall length
  input wire logic        ref_clk,
  input wire logic [1:0]  stall,
  // bus pins
  input wire logic [15:0] ext_data_out,
  input wire logic        ext_bus_direction,
  input wire logic [2:0]  ext_reg_select,
  input wire logic        ext_data_strobe,
  output logic     [15:0] ext_data_in,
  output logic            ext_ready
);
  logic [15:0] regs [8];
  logic [15:0] held_reg = 16'h0;
  logic [1:0]  wait_reg = 2'h0;
  ////////////////////////////////////////
  // latch at the clock edge on which the strobe rises, with the pins as they stood before it
  always @(posedge ref_clk) begin
    if (!ext_data_strobe && ext_ready && !ext_bus_direction) regs[ext_reg_select] <= ext_data_out;
  end
  always @(posedge ref_clk) begin
    held_reg <= ext_data_in;
    if (ext_data_strobe) wait_reg <= stall;
    else if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
  end
  assign ext_ready = (wait_reg == 2'h0);
  // released bus shows a pattern that flips every cycle
  assign ext_data_in = (!ext_data_strobe && ext_bus_direction) ? regs[ext_reg_select] : ~held_reg;
endmodule
`default_nettype wire

// *** ext_register_bus_ctrl_tb.sv ***
// self-checking bench for the external register bus control block
`include "ext_bus_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ext_register_bus_ctrl_tb;
  logic        ref_clk = 0, rst = 1, chip_clear_n = 1, acc_req = 0, acc_read = 0, halt = 0, insn_end = 1;
  logic        irq_enable = 0, acc_done, ext_data_oe, ext_bus_direction, ext_data_strobe, ext_ready, rd_seen = 0;
  logic        vec_rd, pc_load, exec_nop, pc_hold, irq_taken;
  logic [2:0]  acc_sel = 0, ext_reg_select, interrupt_request_lines = 0;
  logic [1:0]  irq_num, branch_test_inputs = 0, branch_test_sync, status_user_bits = 0, user_flag_outputs, stall = 0;
  logic [11:0] vec_addr, vec_data, pc_load_value;
  logic [15:0] acc_wdata = 0, acc_rdata, ext_data_in, ext_data_out, rnd = 16'h46ac, mem [8], exp_q [$];
  int          comparisons = 0, n_mismatch = 0;
  assign vec_data = vec_addr ^ 12'h3c3;
  always #5 ref_clk = ~ref_clk;
  ext_register_bus_ctrl dut (.*);
  ext_periph partner (.*);
  ////////////////////////////////////////
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    return s ^ (s << 8);
  endfunction
  task automatic check_val(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bus_access(input logic rd, input logic [2:0] sel);
    int n = 0;
    rnd = next_rand(rnd);
    stall = rnd[1:0];
    if (rd) exp_q.push_back(mem[sel]);
    else mem[sel] = rnd;
    acc_read = rd;
    acc_sel = sel;
    acc_wdata = rnd;
    acc_req = 1;
    while (acc_done !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40) n_mismatch++;
    @(negedge ref_clk);
    acc_req = 0;
    @(negedge ref_clk);
  endtask
  // result monitor: oldest note is compared when a result shows
  always @(negedge ref_clk) begin
    if (rd_seen) check_val("read data", acc_rdata, exp_q.pop_front());
    if (irq_taken !== 1'b0) check_val("irq number", 16'(irq_num), exp_q.pop_front());
    if (pc_load !== 1'b0) check_val("pc vector", 16'(pc_load_value), exp_q.pop_front());
    rd_seen = acc_done && acc_read;
  end
  initial begin
    exp_q.push_back(16'(`VEC_RESET ^ 12'h3c3));
    repeat (5) @(negedge ref_clk);
    rst = 0;
    repeat (4) @(negedge ref_clk);
    $display("test reset done");
    foreach (mem[i]) bus_access(1'b0, 3'(i));
    foreach (mem[i]) bus_access(1'b1, 3'(i));
    $display("test bus done");
    irq_enable = 1;
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back(16'(k));
      exp_q.push_back(16'((`VEC_INT0 - 12'(k)) ^ 12'h3c3));
    end
    interrupt_request_lines = 3'h7;
    repeat (30) @(negedge ref_clk);
    interrupt_request_lines = 0;
    halt = 1;
    repeat (6) @(negedge ref_clk);
    exp_q.push_back(16'h1);
    exp_q.push_back(16'(`VEC_INT1 ^ 12'h3c3));
    interrupt_request_lines = 3'h2;
    repeat (12) @(negedge ref_clk);
    halt = 0;
    interrupt_request_lines = 0;
    $display("test interrupts done");
    exp_q.push_back(16'(`VEC_RESET ^ 12'h3c3));
    #2 chip_clear_n = 0;
    // a line held high across reset must not raise a request afterwards
    interrupt_request_lines = 3'h4;
    repeat (2) @(negedge ref_clk);
    chip_clear_n = 1;
    repeat (8) @(negedge ref_clk);
    for (int k = 0; k < 20; k++) begin
      rnd = next_rand(rnd);
      {status_user_bits, branch_test_inputs} = rnd[3:0];
      @(negedge ref_clk);
      check_val("user flags", {14'h0, user_flag_outputs}, {14'h0, ~status_user_bits});
    end
    check_val("notes left", 16'(exp_q.size()), 16'h0);
    $display("test user pins done");
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
